// ### design/caw_watchdog.sv
// Purpose: watchdog on compare module 2 of a 16-bit counter array
// Assumes: i_ext_clk, i_eci, i_t0_ovf synchronous to i_clk
// Notes:   reset request is a one-cycle pulse
`timescale 1ns/1ps
// What this block does
// - with enable set, module 2 compares its high byte to counter high byte
// - module 2 low byte holds the refresh offset
// - watchdog comes out of every reset enabled
// - enabled watchdog forces counter running; run-control writes still update the bit
// - enabled watchdog blocks writes to counter low and high bytes
// - enabled watchdog freezes clock-source select and idle-suspend bit
// - enabled watchdog forces module 2 to software timer, blocks mode writes
// - run-control reads zero unless software set it
// - with watchdog enabled, a write to module 2 high loads counter high plus offset
// - reset when low byte overflows while module 2 high equals counter high
// - writing one to module 2 flag while enabled forces reset
// - timeout is 256 times offset plus 256 minus low byte at refresh
// - setting enable or lock bit enables the watchdog
// - lock holds watchdog enabled until next system reset
// - with lock clear, clearing enable disables and releases frozen registers
// - after reset clock is system/12, low byte and offset zero
// - idle-suspend set halts counting in idle; clear keeps running
// - clock-source codes select six sources; two codes reserved
// - mode bit 4 reads zero and ignores writes
module caw_watchdog
    import caw_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // sfr port
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    // system status and count sources
    input  wire logic       i_cpu_idle,
    input  wire logic       i_t0_ovf,
    input  wire logic       i_eci,
    input  wire logic       i_ext_clk,
    // reset request
    output logic            o_wdt_rst
);
    typedef enum logic [1:0] { CAW_ECI_HI = 2'b01, CAW_ECI_LO = 2'b10 } caw_eci_t;

    logic [7:0] ctrl_r;
    logic       idle_suspend_bit_r;
    logic       watchdog_enable_bit_r;
    logic       lck_r;
    logic [2:0] cps_r;
    logic       ecf_r;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] m2_lo_r;
    logic [7:0] m2_hi_r;
    logic [7:0] m2_md_r;
    logic [3:0] div12_r;
    logic [1:0] div4_r;
    logic [2:0] div8_r;
    logic       ext_d_r;
    caw_eci_t   eci_r;
    logic       tick;
    logic       wd_on;
    logic       run;
    logic       wr_ctrl;
    logic       wr_mode;
    logic       lo_ovf;
    logic       m2_match;
    logic       rst_nxt;

    assign wd_on    = watchdog_enable_bit_r | lck_r;
    assign run      = (ctrl_r[CAW_CR_BIT] | wd_on) & ~(idle_suspend_bit_r & i_cpu_idle);
    assign wr_ctrl  = i_sfr_wr && i_sfr_addr == CAW_ADDR_CTRL;
    assign wr_mode  = i_sfr_wr && i_sfr_addr == CAW_ADDR_MODE;
    assign lo_ovf   = run && tick && cnt_lo_r == 8'hFF;
    assign m2_match = m2_hi_r == cnt_hi_r;

    // timebase selection
    always_comb
    begin
        case (cps_r)
            CAW_CPS_DIV12: tick = div12_r == CAW_DIV12_MAX;
            CAW_CPS_DIV4:  tick = div4_r == CAW_DIV4_MAX;
            CAW_CPS_T0OV:  tick = i_t0_ovf;
            CAW_CPS_ECI:   tick = eci_r == CAW_ECI_HI && !i_eci;
            CAW_CPS_SYS:   tick = 1'b1;
            CAW_CPS_EXT8:  tick = div8_r == CAW_DIV8_MAX && !ext_d_r && i_ext_clk;
            default:       tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            div12_r <= '0;
            div4_r  <= '0;
        end
        else
        begin
            div12_r <= (div12_r == CAW_DIV12_MAX) ? 4'h0 : div12_r + 4'h1;
            div4_r  <= div4_r + 2'h1;
        end
    end

    // falling edges on the count input, rising edges on the external clock; a fall needs two samples so rate tops at sys/2
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            eci_r   <= CAW_ECI_LO;
            ext_d_r <= 1'b0;
            div8_r  <= '0;
        end
        else
        begin
            eci_r   <= i_eci ? CAW_ECI_HI : CAW_ECI_LO;
            ext_d_r <= i_ext_clk;
            if (!ext_d_r && i_ext_clk)
                div8_r <= div8_r + 3'h1;
        end
    end

    // control register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ctrl_r <= CAW_CTRL_RST;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r[CAW_CR_BIT] <= i_sfr_wdata[CAW_CR_BIT];
                ctrl_r[2:0]        <= i_sfr_wdata[2:0];
                ctrl_r[CAW_CF_BIT] <= i_sfr_wdata[CAW_CF_BIT];
            end
            // hardware set wins over software clear
            if (run && tick && cnt_lo_r == 8'hFF && cnt_hi_r == 8'hFF)
                ctrl_r[CAW_CF_BIT] <= 1'b1;
            if (run && tick && {cnt_hi_r, cnt_lo_r} + 16'h1 == {m2_hi_r, m2_lo_r} && m2_md_r[3])
                ctrl_r[CAW_MODULE2_MATCH_FLAG_BIT] <= 1'b1;
            ctrl_r[5:3] <= 3'h0;
        end
    end

    // mode register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            idle_suspend_bit_r <= 1'b0;
            watchdog_enable_bit_r <= 1'b1;
            lck_r  <= 1'b0;
            cps_r  <= CAW_CPS_RST;
            ecf_r  <= 1'b0;
        end
        else if (wr_mode)
        begin
            ecf_r  <= i_sfr_wdata[CAW_ECF_BIT];
            lck_r  <= lck_r | i_sfr_wdata[CAW_LCK_BIT];
            watchdog_enable_bit_r <= i_sfr_wdata[CAW_WATCHDOG_ENABLE_BIT_BIT];
            if (!wd_on)
            begin
                idle_suspend_bit_r <= i_sfr_wdata[CAW_IDLE_SUSPEND_BIT_BIT];
                cps_r  <= i_sfr_wdata[CAW_CPS_LSB +: 3];
            end
        end
    end

    // counter
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_lo_r <= 8'h00;
            cnt_hi_r <= 8'h00;
        end
        else if (run && tick)
        begin
            cnt_lo_r <= cnt_lo_r + 8'h01;
            if (cnt_lo_r == 8'hFF)
                cnt_hi_r <= cnt_hi_r + 8'h01;
        end
        else if (i_sfr_wr && !wd_on)
        begin
            if (i_sfr_addr == CAW_ADDR_CNT_LO)
                cnt_lo_r <= i_sfr_wdata;
            if (i_sfr_addr == CAW_ADDR_CNT_HI)
                cnt_hi_r <= i_sfr_wdata;
        end
    end

    // module 2 registers; offset times 256 plus remaining low counts is the timeout
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            m2_lo_r <= 8'h00;
            m2_hi_r <= 8'h00;
            m2_md_r <= CAW_M2MD_RST;
        end
        else
        begin
            if (i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_LO)
                m2_lo_r <= i_sfr_wdata;
            if (i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_HI)
                m2_hi_r <= wd_on ? cnt_hi_r + m2_lo_r : i_sfr_wdata;
            if (wd_on)
                m2_md_r <= CAW_M2MD_SWT;
            else if (i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_MD)
                m2_md_r <= i_sfr_wdata;
        end
    end

    // reset request
    always_comb
    begin
        rst_nxt = wd_on && ((lo_ovf && m2_match)
                  || (wr_ctrl && i_sfr_wdata[CAW_MODULE2_MATCH_FLAG_BIT]));
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_wdt_rst <= 1'b0;
        else
            o_wdt_rst <= rst_nxt && !o_wdt_rst;
    end

    // read data
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
        begin
            case (i_sfr_addr)
                CAW_ADDR_CTRL:   o_sfr_rdata <= ctrl_r;
                CAW_ADDR_MODE:   o_sfr_rdata <= {idle_suspend_bit_r, watchdog_enable_bit_r, lck_r, 1'b0, cps_r, ecf_r};
                CAW_ADDR_CNT_LO: o_sfr_rdata <= cnt_lo_r;
                CAW_ADDR_CNT_HI: o_sfr_rdata <= cnt_hi_r;
                CAW_ADDR_M2_LO:  o_sfr_rdata <= m2_lo_r;
                CAW_ADDR_M2_HI:  o_sfr_rdata <= m2_hi_r;
                CAW_ADDR_M2_MD:  o_sfr_rdata <= m2_md_r;
                default:         o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    a_reset_out_of_reset: assert property (@(posedge i_clk) $fell(i_rst) |-> watchdog_enable_bit_r && cps_r == CAW_CPS_DIV12)
        else $error("watchdog not enabled after reset");
    a_lock_holds_on: assert property (@(posedge i_clk) disable iff (i_rst) lck_r |=> wd_on && lck_r)
        else $error("lock released without reset");
    a_counter_forced_run: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && !(idle_suspend_bit_r && i_cpu_idle) && tick |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
        else $error("counter did not run under watchdog");
    a_freeze_source: assert property (@(posedge i_clk) disable iff (i_rst) wd_on |=> $stable(cps_r) && $stable(idle_suspend_bit_r))
        else $error("frozen field changed");
    a_timeout_reset: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && lo_ovf && m2_match && !o_wdt_rst |=> o_wdt_rst)
        else $error("missed timeout reset");
    a_forced_reset: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && wr_ctrl && i_sfr_wdata[CAW_MODULE2_MATCH_FLAG_BIT] && !o_wdt_rst |=> o_wdt_rst)
        else $error("forced reset missing");
    a_refresh_load: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_HI |=> m2_hi_r == $past(cnt_hi_r) + $past(m2_lo_r))
        else $error("refresh loaded wrong value");
    a_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst) o_wdt_rst |=> !o_wdt_rst)
        else $error("reset request longer than one cycle");
    a_idle_halt: assert property (@(posedge i_clk) disable iff (i_rst)
        idle_suspend_bit_r && i_cpu_idle && !(i_sfr_wr && !wd_on) |=> $stable(cnt_lo_r))
        else $error("counter ran in idle");
    c_timeout: cover property (@(posedge i_clk) o_wdt_rst && !wr_ctrl);
    c_refresh: cover property (@(posedge i_clk) wd_on && i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_HI);
    c_disable: cover property (@(posedge i_clk) $fell(wd_on));
    c_lock: cover property (@(posedge i_clk) $rose(lck_r));
    c_forced: cover property (@(posedge i_clk) wd_on && wr_ctrl && i_sfr_wdata[CAW_MODULE2_MATCH_FLAG_BIT]);

    // enable and lock control
    a_lock_enables: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_mode && i_sfr_wdata[CAW_LCK_BIT] |=> lck_r && wd_on)
        else $error("lock bit did not enable watchdog");
    a_enable_sets: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_mode && i_sfr_wdata[CAW_WATCHDOG_ENABLE_BIT_BIT] |=> wd_on)
        else $error("enable bit did not enable watchdog");
    a_unlocked_off: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_mode && !lck_r && !i_sfr_wdata[CAW_WATCHDOG_ENABLE_BIT_BIT] && !i_sfr_wdata[CAW_LCK_BIT] |=> !wd_on)
        else $error("unlocked watchdog not disabled");

    // write blocking, forced module 2 mode, read-back, offset load and reset checks
    a_count_hi_block: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && i_sfr_wr && i_sfr_addr == CAW_ADDR_CNT_HI && !lo_ovf |=> $stable(cnt_hi_r))
        else $error("counter high byte written under watchdog");
    a_m2_mode_forced: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on |=> m2_md_r == CAW_M2MD_SWT)
        else $error("module 2 not in software timer mode");
    a_cr_soft_only: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl && !i_sfr_wdata[CAW_CR_BIT] |=> !ctrl_r[CAW_CR_BIT])
        else $error("run-control reads one without software");
    a_mode_bit4_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sfr_rd && i_sfr_addr == CAW_ADDR_MODE |=> !o_sfr_rdata[4])
        else $error("unused mode bit read as one");
    a_offset_load: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sfr_wr && i_sfr_addr == CAW_ADDR_M2_LO |=> m2_lo_r == $past(i_sfr_wdata))
        else $error("offset byte not loaded");
    a_reset_defaults: assert property (@(posedge i_clk) $fell(i_rst) |-> cnt_lo_r == 8'h00 && m2_lo_r == 8'h00)
        else $error("counter or offset not zero after reset");
    a_no_rst_off: assert property (@(posedge i_clk) disable iff (i_rst)
        !wd_on |=> !o_wdt_rst)
        else $error("reset request with watchdog disabled");

    // timebase source, spacing and idle-clear checks; a back-to-back div4 or div12 tick means a divider is broken
    a_reserved_source: assert property (@(posedge i_clk) disable iff (i_rst)
        cps_r[2:1] == 2'b11 |-> !tick)
        else $error("reserved source produced a tick");
    a_div4_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
        cps_r == CAW_CPS_DIV4 && tick && !wr_mode |=> !tick)
        else $error("divide by four ticked twice in a row");
    a_div12_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
        cps_r == CAW_CPS_DIV12 && tick && !wr_mode |=> !tick)
        else $error("divide by twelve ticked twice in a row");
    a_t0_source: assert property (@(posedge i_clk) disable iff (i_rst)
        cps_r == CAW_CPS_T0OV |-> tick == i_t0_ovf)
        else $error("timer 0 source not followed");
    a_eci_fall_only: assert property (@(posedge i_clk) disable iff (i_rst)
        cps_r == CAW_CPS_ECI && tick |-> !i_eci)
        else $error("count input ticked without a fall");
    a_idle_clear_runs: assert property (@(posedge i_clk) disable iff (i_rst)
        wd_on && !idle_suspend_bit_r && tick |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
        else $error("counter stopped with idle-suspend clear");
endmodule

// ### dv/caw_watchdog_tb.sv
// Purpose: self-checking bench for caw_watchdog
// Assumes: read data lands one cycle after the read strobe
// Notes:   count sources run off a free cycle counter
`timescale 1ns/1ps
module caw_watchdog_tb;
    import caw_pkg::*;
    localparam logic [7:0] TICKS [0:5] = '{8'h08, 8'h18, 8'h18, 8'h0C, 8'h60, 8'h06};
    logic       i_clk       = 1'b0;
    logic       i_rst       = 1'b1;
    logic       i_sfr_wr    = 1'b0;
    logic       i_sfr_rd    = 1'b0;
    logic [7:0] i_sfr_addr  = 8'h00;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic [7:0] o_sfr_rdata;
    logic       i_cpu_idle  = 1'b0;
    logic       i_t0_ovf    = 1'b0;
    logic       i_eci       = 1'b0;
    logic       i_ext_clk   = 1'b0;
    logic       o_wdt_rst;
    logic [7:0] rd;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] off;
    int         error_cnt   = 0;
    int         checked     = 0;
    int         cyc         = 0;
    int         seed        = 54;
    int         tw;
    int         tdet;
    int         span;

    caw_watchdog u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
        .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
        .i_cpu_idle(i_cpu_idle), .i_t0_ovf(i_t0_ovf), .i_eci(i_eci), .i_ext_clk(i_ext_clk),
        .o_wdt_rst(o_wdt_rst));

    always #4 i_clk = ~i_clk;

    // t0 pulse every 4, eci falls every 8, ext clock rises every 2
    always @(posedge i_clk)
    begin
        cyc       <= cyc + 1;
        i_t0_ovf  <= #1 (cyc[1:0] == 2'h0);
        i_eci     <= #1 cyc[2];
        i_ext_clk <= #1 cyc[0];
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out;
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // counts carry pipeline slack, so they are compared within a window
    function automatic logic [15:0] near(input int seen, input int exp, input int tol);
        return (seen >= exp - tol && seen <= exp + tol) ? 16'(exp) : 16'(seen);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        i_sfr_wr    = 1'b1;
        i_sfr_addr  = a;
        i_sfr_wdata = d;
        @(posedge i_clk);
        #1;
        i_sfr_wr    = 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        i_sfr_rd   = 1'b1;
        i_sfr_addr = a;
        @(posedge i_clk);
        #1;
        i_sfr_rd   = 1'b0;
        d          = o_sfr_rdata;
    endtask

    task automatic do_rst;
        @(posedge i_clk);
        #1;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        tw    = cyc;
    endtask

    task automatic wait_wdt(input int lim);
        span = 0;
        while (o_wdt_rst !== 1'b1 && span < lim)
        begin
            @(posedge i_clk);
            #1;
            span++;
        end
        tdet = cyc;
        chk("wdt_rst", o_wdt_rst, 16'h0001);
        @(posedge i_clk);
        #1;
        chk("wdt_rst_width", o_wdt_rst, 16'h0000);
    endtask

    initial
    begin
        do_rst;
        rdr(CAW_ADDR_MODE, rd);
        chk("mode_rst", rd, 16'h0040);
        rdr(CAW_ADDR_M2_LO, rd);
        chk("offset_rst", rd, 16'h0000);
        rdr(8'h00, rd);
        chk("unmapped", rd, 16'h0000);
        rdr(CAW_ADDR_CTRL, rd);
        chk("cr_read", rd & 8'h40, 16'h0000);
        wr(CAW_ADDR_CNT_HI, 8'h55);
        wr(CAW_ADDR_MODE, 8'h5E);
        wr(CAW_ADDR_M2_MD, 8'h00);
        rdr(CAW_ADDR_CNT_HI, rd);
        chk("cnt_hi_frozen", rd, 16'h0000);
        rdr(CAW_ADDR_MODE, rd);
        chk("mode_frozen", rd, 16'h0040);
        rdr(CAW_ADDR_M2_MD, rd);
        chk("m2_mode", rd, 16'(CAW_M2MD_SWT));
        rdr(CAW_ADDR_CNT_LO, lo);
        repeat (30) @(posedge i_clk);
        rdr(CAW_ADDR_CNT_LO, rd);
        chk("cnt_forced_on", rd == lo, 16'h0000);
        wr(CAW_ADDR_CTRL, 8'h40);
        rdr(CAW_ADDR_CTRL, rd);
        chk("cr_set", rd & 8'h40, 16'h0040);
        wait_wdt(4000);
        chk("default_timeout", near(tdet - tw, 3072, 8), 16'h0C00);
        do_rst;
        wr(CAW_ADDR_CTRL, 8'h04);
        wait_wdt(3);
        do_rst;
        wr(CAW_ADDR_MODE, 8'h20);
        wr(CAW_ADDR_MODE, 8'h08);
        rdr(CAW_ADDR_MODE, rd);
        chk("lock_held", rd & 8'h2E, 16'h0020);
        wr(CAW_ADDR_CNT_HI, 8'h33);
        rdr(CAW_ADDR_CNT_HI, rd);
        chk("lock_frozen", rd, 16'h0000);
        do_rst;
        wr(CAW_ADDR_MODE, 8'h00);
        wr(CAW_ADDR_CNT_HI, 8'h5A);
        rdr(CAW_ADDR_CNT_HI, rd);
        chk("released", rd, 16'h005A);
        for (int c = 0; c < 6; c++)
        begin
            wr(CAW_ADDR_MODE, 8'(c << CAW_CPS_LSB));
            wr(CAW_ADDR_CNT_LO, 8'h00);
            wr(CAW_ADDR_CTRL, 8'h40);
            repeat (94) @(posedge i_clk);
            wr(CAW_ADDR_CTRL, 8'h00);
            rdr(CAW_ADDR_CNT_LO, rd);
            chk("source_ticks", near(rd, TICKS[c], 1), 16'(TICKS[c]));
        end
        wr(CAW_ADDR_MODE, 8'h88);
        wr(CAW_ADDR_CTRL, 8'h40);
        i_cpu_idle = 1'b1;
        rdr(CAW_ADDR_CNT_LO, lo);
        rdr(CAW_ADDR_CNT_LO, rd);
        chk("idle_halt", rd, 16'(lo));
        i_cpu_idle = 1'b0;
        rdr(CAW_ADDR_CNT_LO, rd);
        chk("idle_resume", rd == lo, 16'h0000);
        repeat (4)
        begin
            do_rst;
            off = 8'($unsigned($random(seed)) % 4);
            lo  = 8'($unsigned($random(seed)) % 224);
            hi  = 8'($random(seed));
            // disable, load counter and offset, then pick system clock while re-enabling
            wr(CAW_ADDR_MODE, 8'h08);
            wr(CAW_ADDR_CNT_LO, lo);
            wr(CAW_ADDR_CNT_HI, hi);
            wr(CAW_ADDR_M2_LO, off);
            wr(CAW_ADDR_MODE, 8'h48);
            wr(CAW_ADDR_M2_HI, 8'($random(seed)));
            tw = cyc;
            i_cpu_idle = 1'($random(seed));
            rdr(CAW_ADDR_M2_HI, rd);
            chk("refresh", rd, 16'(8'(hi + off)));
            wait_wdt(1400);
            chk("timeout", near(tdet - tw, 256 * off + 256 - lo, 6), 16'(256 * off + 256 - lo));
        end
        close_out();
    end
endmodule

// ### include/caw_pkg.sv
// Purpose: constants for the counter array watchdog
// Assumes: byte-wide special function register port
// Notes:   offsets are register addresses on the sfr port
package caw_pkg;
    localparam logic [7:0] CAW_ADDR_CTRL   = 8'hD8;
    localparam logic [7:0] CAW_ADDR_MODE   = 8'hD9;
    localparam logic [7:0] CAW_ADDR_CNT_LO = 8'hE9;
    localparam logic [7:0] CAW_ADDR_CNT_HI = 8'hF9;
    localparam logic [7:0] CAW_ADDR_M2_LO  = 8'hED;
    localparam logic [7:0] CAW_ADDR_M2_HI  = 8'hFD;
    localparam logic [7:0] CAW_ADDR_M2_MD  = 8'hDC;
    // control register fields
    localparam int CAW_CF_BIT   = 7;
    localparam int CAW_CR_BIT   = 6;
    localparam int CAW_MODULE2_MATCH_FLAG_BIT = 2;
    // mode register fields
    localparam int CAW_IDLE_SUSPEND_BIT_BIT = 7;
    localparam int CAW_WATCHDOG_ENABLE_BIT_BIT = 6;
    localparam int CAW_LCK_BIT  = 5;
    localparam int CAW_CPS_LSB  = 1;
    localparam int CAW_ECF_BIT  = 0;
    // reset values
    localparam logic [7:0] CAW_CTRL_RST  = 8'h00;
    localparam logic [2:0] CAW_CPS_RST   = 3'h0;
    localparam logic [7:0] CAW_M2MD_RST  = 8'h00;
    // software timer mode: comparator and match enabled
    localparam logic [7:0] CAW_M2MD_SWT  = 8'h48;
    // clock source codes
    localparam logic [2:0] CAW_CPS_DIV12 = 3'h0;
    localparam logic [2:0] CAW_CPS_DIV4  = 3'h1;
    localparam logic [2:0] CAW_CPS_T0OV  = 3'h2;
    localparam logic [2:0] CAW_CPS_ECI   = 3'h3;
    localparam logic [2:0] CAW_CPS_SYS   = 3'h4;
    localparam logic [2:0] CAW_CPS_EXT8  = 3'h5;
    localparam logic [3:0] CAW_DIV12_MAX = 4'hB;
    localparam logic [1:0] CAW_DIV4_MAX  = 2'h3;
    localparam logic [2:0] CAW_DIV8_MAX  = 3'h7;
endpackage
